// File: slc_defs.svh
// Register offsets, field positions, reset values and link constants.
`ifndef SLC_DEFS_SVH
`define SLC_DEFS_SVH
`define SLC_A_MODE      12'h200
`define SLC_A_DCM       12'h201
`define SLC_A_FMT       12'h561
`define SLC_A_LRATE     12'h56E
`define SLC_A_QCFG      12'h570
`define SLC_A_LCTL      12'h571
`define SLC_A_DEM0      12'h5C1
`define SLC_A_DEM4      12'h5C5
`define SLC_A_STAT      12'h5F0
`define SLC_QIGN_BIT    5
`define SLC_LOWRATE_BIT 4
`define SLC_PD_BIT      0
`define SLC_FMT_BIT     0
`define SLC_MODE_ONE    4'h1
`define SLC_MODE_TWO    4'h2
`define SLC_MODE_FOUR   4'h3
`define SLC_MODE_REQ    4'h7
`define SLC_MODE_DYN    4'h8
`define SLC_RST_MODE    8'h01
`define SLC_RST_DCM     8'h01
`define SLC_RST_QCFG    8'h49
`define SLC_RST_ZERO    8'h00
`define SLC_LOWRATE_VAL 8'h10
`define SLC_PD_VAL      8'h01
`define SLC_RATE_MIN    3125
`define SLC_RATE_LOW    6250
`define SLC_RATE_MAX    12500
`define SLC_ENC_NUM     10
`define SLC_ENC_DEN     8
`define SLC_NVC         8
`define SLC_NDDC        4
`define SLC_NP          16
`endif

// File: slc_pkg.sv
// Types shared by both ends of the converter mapping link.
package slc_pkg;
  `include "slc_defs.svh"
  typedef logic [`SLC_NP-1:0] slc_smp_t;
  typedef slc_smp_t [`SLC_NVC-1:0] slc_frame_t;
  typedef struct packed {
    logic [`SLC_NVC-1:0] used;
    slc_frame_t          smp;
  } slc_word_t;
  typedef enum {HS_IDLE, HS_PD, HS_QCFG, HS_MODE, HS_DCM, HS_LRATE, HS_PU, HS_CHK,
                HS_WAIT} slc_hst_t;
endpackage : slc_pkg

// File: slc_if.sv
// Interface joining the device end and the receiver end.
`timescale 1ns/1ps
interface slc_if
  import slc_pkg::*;
();
  logic       cfg_wr;
  logic       cfg_rd;
  logic [11:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic       cfg_rvalid;
  slc_word_t  lane_word;
  logic       lane_valid;
  logic       lane_ready;
  modport dev (input cfg_wr, cfg_rd, cfg_addr, cfg_wdata, lane_ready,
               output cfg_rdata, cfg_rvalid, lane_word, lane_valid);
  modport host (output cfg_wr, cfg_rd, cfg_addr, cfg_wdata, lane_ready,
                input cfg_rdata, cfg_rvalid, lane_word, lane_valid);
endinterface : slc_if

// File: slc_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module slc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Fill side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule : slc_fifo

// File: slc_dev.sv
// Device end: register file, virtual converter mapping and lane output.
`timescale 1ns/1ps
`include "slc_defs.svh"
module slc_dev
  import slc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // Link side.
  slc_if.dev                           lnk,
  // Converter samples.
  input  wire logic                    smp_valid,
  output logic                         smp_ready,
  input  wire slc_smp_t [`SLC_NDDC-1:0] ddc_i,
  input  wire slc_smp_t [`SLC_NDDC-1:0] ddc_q,
  input  wire slc_smp_t                adc_a,
  input  wire slc_smp_t                adc_b,
  // Status.
  output logic                         drv_pd,
  output logic                         pll_low_rate,
  output logic                         deemph_en,
  output logic [7:0]                   lane_mult,
  output logic [3:0]                   vc_count,
  output logic                         m_mismatch
);
  logic [7:0]  mode_r;
  logic [7:0]  dcm_r;
  logic [7:0]  fmt_r;
  logic [7:0]  lrate_r;
  logic [7:0]  qcfg_r;
  logic [7:0]  lctl_r;
  logic [7:0]  dem_r [5];
  logic [7:0]  rdata_r;
  logic        rvalid_r;
  logic [7:0]  lane_mult_r;
  logic [3:0]  vc_count_r;
  logic        mismatch_r;
  logic        deemph_r;
  slc_word_t   map_w;
  logic [3:0]  vcnt_w;
  logic [3:0]  qm_w;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  slc_word_t   fifo_out_data;

  // ****************************************************************
  // Register writes.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_r  <= `SLC_RST_MODE;
      dcm_r   <= `SLC_RST_DCM;
      fmt_r   <= `SLC_RST_ZERO;
      lrate_r <= `SLC_RST_ZERO;
      qcfg_r  <= `SLC_RST_QCFG;
      lctl_r  <= `SLC_RST_ZERO;
    end else if (lnk.cfg_wr) begin
      unique case (lnk.cfg_addr)
        `SLC_A_MODE:  mode_r  <= lnk.cfg_wdata;
        `SLC_A_DCM:   dcm_r   <= lnk.cfg_wdata;
        `SLC_A_FMT:   fmt_r   <= lnk.cfg_wdata;
        `SLC_A_LRATE: lrate_r <= lnk.cfg_wdata;
        `SLC_A_QCFG:  qcfg_r  <= lnk.cfg_wdata;
        `SLC_A_LCTL:  lctl_r  <= lnk.cfg_wdata;
        default:      ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int k = 0; k < 5; k++) begin
      if (!rst_n) begin
        dem_r[k] <= `SLC_RST_ZERO;
      end else if (lnk.cfg_wr && lnk.cfg_addr == `SLC_A_DEM0 + 12'(k)) begin
        dem_r[k] <= lnk.cfg_wdata;
      end
    end
  end

  // ****************************************************************
  // Register reads.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= lnk.cfg_rd;
      if (lnk.cfg_rd) begin
        rdata_r <= 8'h00;
        if (lnk.cfg_addr >= `SLC_A_DEM0 && lnk.cfg_addr <= `SLC_A_DEM4) begin
          rdata_r <= dem_r[3'(lnk.cfg_addr - `SLC_A_DEM0)];
        end
        unique case (lnk.cfg_addr)
          `SLC_A_MODE:  rdata_r <= mode_r;
          `SLC_A_DCM:   rdata_r <= dcm_r;
          `SLC_A_FMT:   rdata_r <= fmt_r;
          `SLC_A_LRATE: rdata_r <= lrate_r;
          `SLC_A_QCFG:  rdata_r <= qcfg_r;
          `SLC_A_LCTL:  rdata_r <= lctl_r;
          `SLC_A_STAT:  rdata_r <= {6'h00, ~fifo_in_ready, mismatch_r};
          default:      ;
        endcase
      end
    end
  end

  assign lnk.cfg_rdata  = rdata_r;
  assign lnk.cfg_rvalid = rvalid_r;

  // ****************************************************************
  // Virtual converter mapping.
  // ****************************************************************
  function automatic slc_smp_t fmt_s(input slc_smp_t s, input logic ob);
    fmt_s = s ^ {ob, {(`SLC_NP-1){1'b0}}};
  endfunction : fmt_s

  always_comb begin
    int   nd;
    logic ab;
    logic qign;
    logic ob;
    nd        = 0;
    ab        = 1'b0;
    qign      = mode_r[`SLC_QIGN_BIT];
    ob        = fmt_r[`SLC_FMT_BIT];
    map_w     = '0;
    unique case (mode_r[3:0])
      `SLC_MODE_ONE:  nd = 1;
      `SLC_MODE_TWO:  nd = 2;
      `SLC_MODE_FOUR: nd = 4;
      `SLC_MODE_REQ,
      `SLC_MODE_DYN:  ab = 1'b1;
      default:        nd = 0;
    endcase
    for (int n = 0; n < `SLC_NDDC; n++) begin
      if (n < nd) begin
        if (qign) begin
          map_w.smp[n]  = fmt_s(ddc_i[n], ob);
          map_w.used[n] = 1'b1;
        end else begin
          map_w.smp[2*n]    = fmt_s(ddc_i[n], ob);
          map_w.smp[2*n+1]  = fmt_s(ddc_q[n], ob);
          map_w.used[2*n]   = 1'b1;
          map_w.used[2*n+1] = 1'b1;
        end
      end
    end
    if (ab) begin
      map_w.smp[0]  = fmt_s(adc_a, ob);
      map_w.smp[1]  = fmt_s(adc_b, ob);
      map_w.used[0] = 1'b1;
      map_w.used[1] = 1'b1;
    end
    vcnt_w = ab ? 4'h2 : (qign ? 4'(nd) : 4'(2 * nd));
  end

  // ****************************************************************
  // Quick configuration decode and lane rate factor.
  // ****************************************************************
  always_comb begin
    unique case (qcfg_r)
      8'h01, 8'h40, 8'h41, 8'h80, 8'h81: qm_w = 4'h1;
      8'h0A, 8'h49, 8'h88, 8'h89:        qm_w = 4'h2;
      8'h13, 8'h52, 8'h91:               qm_w = 4'h4;
      8'h1C, 8'h5B, 8'h9A:               qm_w = 4'h8;
      default:                           qm_w = 4'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lane_mult_r <= 8'h00;
      vc_count_r  <= 4'h0;
      mismatch_r  <= 1'b0;
      deemph_r    <= 1'b0;
    end else begin
      lane_mult_r <= 8'((16'(qm_w) * `SLC_NP * `SLC_ENC_NUM / `SLC_ENC_DEN)
                        >> qcfg_r[7:6]);
      vc_count_r  <= vcnt_w;
      mismatch_r  <= (qm_w != vcnt_w);
      deemph_r    <= (dem_r[0] | dem_r[1] | dem_r[2] | dem_r[3] | dem_r[4]) != 8'h00;
    end
  end

  assign lane_mult    = lane_mult_r;
  assign vc_count     = vc_count_r;
  assign m_mismatch   = mismatch_r;
  assign deemph_en    = deemph_r;
  assign drv_pd       = lctl_r[`SLC_PD_BIT];
  assign pll_low_rate = lrate_r[`SLC_LOWRATE_BIT];

  // ****************************************************************
  // Frame buffer and the single lane output.
  // ****************************************************************
  slc_fifo #(
    .W ($bits(slc_word_t)),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (smp_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (map_w),
    .out_valid (fifo_out_valid),
    .out_ready (lnk.lane_ready & ~lctl_r[`SLC_PD_BIT]),
    .out_data  (fifo_out_data)
  );

  assign smp_ready      = fifo_in_ready;
  assign lnk.lane_valid = fifo_out_valid & ~lctl_r[`SLC_PD_BIT];
  assign lnk.lane_word  = fifo_out_data;
endmodule : slc_dev

// File: slc_host.sv
// Receiver end: link configuration sequence and frame intake.
`timescale 1ns/1ps
`include "slc_defs.svh"
module slc_host
  import slc_pkg::*;
#(
  parameter int ADC_MHZ = 1000
) (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Link side.
  slc_if.host             lnk,
  // Configuration request.
  input  wire logic       start,
  input  wire logic [7:0] set_mode,
  input  wire logic [7:0] set_qcfg,
  input  wire logic [7:0] set_dcm,
  output logic            busy,
  output logic            done,
  output logic            rate_err,
  output logic            cfg_err,
  output logic            low_rate,
  // Received frames.
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output slc_word_t       rx_word
);
  slc_hst_t   st_r;
  logic [7:0] mode_r;
  logic [7:0] qcfg_r;
  logic [7:0] dcm_r;
  logic       wr_r;
  logic       rd_r;
  logic [11:0] addr_r;
  logic [7:0] wdata_r;
  logic       done_r;
  logic       rerr_r;
  logic       cerr_r;
  logic       low_r;
  logic       rdy_r;
  logic       rxv_r;
  slc_word_t  rxw_r;
  int         m_w;
  int         rate_w;
  logic       ok_w;

  // ****************************************************************
  // Lane rate from the requested settings.
  // ****************************************************************
  always_comb begin
    m_w = 0;
    unique case (set_mode[3:0])
      `SLC_MODE_ONE:  m_w = 1;
      `SLC_MODE_TWO:  m_w = 2;
      `SLC_MODE_FOUR: m_w = 4;
      `SLC_MODE_REQ,
      `SLC_MODE_DYN:  m_w = 1;
      default:        m_w = 0;
    endcase
    if (!set_mode[`SLC_QIGN_BIT]) begin
      m_w = 2 * m_w;
    end
    rate_w = 0;
    if (set_dcm != 8'h00) begin
      rate_w = (m_w * `SLC_NP * `SLC_ENC_NUM * ADC_MHZ)
               / (`SLC_ENC_DEN * (1 << set_qcfg[7:6]) * int'(set_dcm));
    end
    ok_w = (rate_w >= `SLC_RATE_MIN) && (rate_w <= `SLC_RATE_MAX);
  end

  // ****************************************************************
  // Configuration sequence.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r   <= HS_IDLE;
      mode_r <= 8'h00;
      qcfg_r <= 8'h00;
      dcm_r  <= 8'h00;
      low_r  <= 1'b0;
      rerr_r <= 1'b0;
      cerr_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        HS_IDLE: if (start) begin
          rerr_r <= ~ok_w;
          if (ok_w) begin
            mode_r <= set_mode;
            qcfg_r <= set_qcfg;
            dcm_r  <= set_dcm;
            low_r  <= (rate_w < `SLC_RATE_LOW);
            st_r   <= HS_PD;
          end
        end
        HS_PD:    st_r <= HS_QCFG;
        HS_QCFG:  st_r <= HS_MODE;
        HS_MODE:  st_r <= HS_DCM;
        HS_DCM:   st_r <= HS_LRATE;
        HS_LRATE: st_r <= HS_PU;
        HS_PU:    st_r <= HS_CHK;
        HS_CHK:   st_r <= HS_WAIT;
        HS_WAIT: if (lnk.cfg_rvalid) begin
          cerr_r <= lnk.cfg_rdata[0];
          done_r <= 1'b1;
          st_r   <= HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      addr_r  <= 12'h000;
      wdata_r <= 8'h00;
    end else begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      unique case (st_r)
        HS_PD: begin
          wr_r    <= 1'b1;
          addr_r  <= `SLC_A_LCTL;
          wdata_r <= `SLC_PD_VAL;
        end
        HS_QCFG: begin
          wr_r    <= 1'b1;
          addr_r  <= `SLC_A_QCFG;
          wdata_r <= qcfg_r;
        end
        HS_MODE: begin
          wr_r    <= 1'b1;
          addr_r  <= `SLC_A_MODE;
          wdata_r <= mode_r;
        end
        HS_DCM: begin
          wr_r    <= 1'b1;
          addr_r  <= `SLC_A_DCM;
          wdata_r <= dcm_r;
        end
        HS_LRATE: begin
          wr_r    <= 1'b1;
          addr_r  <= `SLC_A_LRATE;
          wdata_r <= low_r ? `SLC_LOWRATE_VAL : `SLC_RST_ZERO;
        end
        HS_PU: begin
          wr_r    <= 1'b1;
          addr_r  <= `SLC_A_LCTL;
          wdata_r <= `SLC_RST_ZERO;
        end
        HS_CHK: begin
          rd_r   <= 1'b1;
          addr_r <= `SLC_A_STAT;
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Frame intake.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdy_r <= 1'b0;
      rxv_r <= 1'b0;
      rxw_r <= '0;
    end else begin
      rdy_r <= rx_ready;
      rxv_r <= lnk.lane_valid & rdy_r;
      if (lnk.lane_valid && rdy_r) begin
        rxw_r <= lnk.lane_word;
      end
    end
  end

  assign lnk.cfg_wr     = wr_r;
  assign lnk.cfg_rd     = rd_r;
  assign lnk.cfg_addr   = addr_r;
  assign lnk.cfg_wdata  = wdata_r;
  assign lnk.lane_ready = rdy_r;
  assign busy           = (st_r != HS_IDLE);
  assign done           = done_r;
  assign rate_err       = rerr_r;
  assign cfg_err        = cerr_r;
  assign low_rate       = low_r;
  assign rx_valid       = rxv_r;
  assign rx_word        = rxw_r;
endmodule : slc_host

// File: slc_assertions.sv
// Concurrent checks on the link interface joining the two ends.
`timescale 1ns/1ps
`include "slc_defs.svh"
module slc_assertions
  import slc_pkg::*;
#(
  parameter int ADC_MHZ = 1000
) (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Register bus.
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0]  cfg_wdata,
  input wire logic [7:0]  cfg_rdata,
  input wire logic        cfg_rvalid,
  // Lane.
  input wire slc_word_t   lane_word,
  input wire logic        lane_valid,
  input wire logic        lane_ready
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [7:0] mode_r;
  logic [7:0] qcfg_r;
  logic [7:0] dcm_r;
  logic       zero_ok;
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Shadows the link settings written by the receiver end.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_r <= `SLC_RST_MODE;
      qcfg_r <= `SLC_RST_QCFG;
      dcm_r  <= `SLC_RST_DCM;
    end else if (cfg_wr) begin
      if (cfg_addr == `SLC_A_MODE) mode_r <= cfg_wdata;
      if (cfg_addr == `SLC_A_QCFG) qcfg_r <= cfg_wdata;
      if (cfg_addr == `SLC_A_DCM) dcm_r <= cfg_wdata;
    end
  end
  // Flags a sample in a slot marked unused.
  always_comb begin
    zero_ok = 1'b1;
    for (int k = 0; k < `SLC_NVC; k++) begin
      if (!lane_word.used[k] && lane_word.smp[k] != 16'h0000) zero_ok = 1'b0;
    end
  end
  function automatic logic low_exp(input logic [7:0] m, input logic [7:0] q, input logic [7:0] d);
    int mm;
    int rate;
    case (m[3:0])
      4'h1, 4'h7, 4'h8: mm = 1;
      4'h2: mm = 2;
      4'h3: mm = 4;
      default: mm = 0;
    endcase
    if (!m[5]) mm = mm * 2;
    rate = (d == 8'h00) ? 0 : mm * 16 * 10 * ADC_MHZ / (8 * (1 << q[7:6]) * int'(d));
    return (rate < 6250);
  endfunction : low_exp
  // ****************************************
  // Sequences
  // ****************************************
  sequence s_pd_on;
    cfg_wr && cfg_addr == `SLC_A_LCTL && cfg_wdata[0];
  endsequence
  sequence s_setup;
    cfg_wr && cfg_addr == `SLC_A_QCFG ##1 cfg_wr && cfg_addr == `SLC_A_MODE
      ##1 cfg_wr && cfg_addr == `SLC_A_DCM ##1 cfg_wr && cfg_addr == `SLC_A_LRATE;
  endsequence
  sequence s_pu;
    cfg_wr && cfg_addr == `SLC_A_LCTL && !cfg_wdata[0];
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  AST_RD_ANSWER: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read strobe without answer next cycle");
  AST_RVALID_CAUSE: assert property (cfg_rvalid |-> $past(cfg_rd))
    else $error("read answer without a read");
  AST_RDATA_HOLD: assert property (!cfg_rvalid |-> $stable(cfg_rdata))
    else $error("read data moved without an answer");
  AST_LANE_HOLD: assert property (lane_valid && !lane_ready
    && !(cfg_wr && cfg_addr == `SLC_A_LCTL && cfg_wdata[0])
    |=> lane_valid && $stable(lane_word))
    else $error("stalled lane word not held");
  AST_USED_SET: assert property (lane_valid
    |-> lane_word.used inside {8'h00, 8'h01, 8'h03, 8'h0F, 8'hFF})
    else $error("virtual converter slots not packed from slot zero");
  AST_UNUSED_ZERO: assert property (lane_valid |-> zero_ok)
    else $error("unused slot carries data");
  AST_CFG_ORDER: assert property (s_pd_on |=> s_setup ##1 s_pu
    ##1 (cfg_rd && cfg_addr == `SLC_A_STAT))
    else $error("link setup steps out of order");
  AST_LOW_RATE: assert property (cfg_wr && cfg_addr == `SLC_A_LRATE
    |-> cfg_wdata == (low_exp(mode_r, qcfg_r, dcm_r) ? `SLC_LOWRATE_VAL : 8'h00))
    else $error("low rate setting does not match the lane rate");
endmodule : slc_assertions

// File: testbench.sv
// Self-checking bench for both ends of the converter mapping link.
`timescale 1ns/1ps
`include "slc_defs.svh"
module testbench;
  import slc_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic                     ref_clk, rst_n, smp_valid, start, rx_ready;
  slc_smp_t [`SLC_NDDC-1:0] ddc_i, ddc_q;
  slc_smp_t                 adc_a, adc_b;
  logic [7:0]               set_mode, set_qcfg, set_dcm, lane_mult;
  logic                     smp_ready, drv_pd, pll_low_rate, deemph_en, m_mismatch;
  logic                     busy, done, rate_err, cfg_err, low_rate, rx_valid;
  logic [3:0]               vc_count;
  slc_word_t                rx_word;
  int                       miscompares, n_checks, cycles;
  logic [7:0] tm[9] = '{8'h01, 8'h21, 8'h22, 8'h02, 8'h23, 8'h03, 8'h07, 8'h08, 8'h03};
  logic [7:0] tq[9] = '{8'h49, 8'h01, 8'h49, 8'h52, 8'h91, 8'h9A, 8'h49, 8'h49, 8'h49};
  logic [7:0] td[9] = '{8'h02, 8'h04, 8'h02, 8'h04, 8'h04, 8'h04, 8'h02, 8'h04, 8'h08};
  logic [7:0] tx[9] = '{8'h14, 8'h14, 8'h14, 8'h28, 8'h14, 8'h28, 8'h14, 8'h14, 8'h14};
  logic [3:0] tv[9] = '{4'h2, 4'h1, 4'h2, 4'h4, 4'h4, 4'h8, 4'h2, 4'h2, 4'h8};
  logic       tl[9] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  // ****************************************
  // Design and checker
  // ****************************************
  slc_if slc_if_i ();
  slc_dev #(.FIFO_DEPTH(4)) slc_dev_i (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(slc_if_i),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .ddc_i(ddc_i), .ddc_q(ddc_q),
    .adc_a(adc_a), .adc_b(adc_b), .drv_pd(drv_pd), .pll_low_rate(pll_low_rate),
    .deemph_en(deemph_en), .lane_mult(lane_mult), .vc_count(vc_count),
    .m_mismatch(m_mismatch));
  slc_host #(.ADC_MHZ(1000)) slc_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(slc_if_i),
    .start(start), .set_mode(set_mode), .set_qcfg(set_qcfg), .set_dcm(set_dcm), .busy(busy),
    .done(done), .rate_err(rate_err), .cfg_err(cfg_err), .low_rate(low_rate),
    .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_word(rx_word));
  slc_assertions #(.ADC_MHZ(1000)) slc_assertions_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .cfg_wr(slc_if_i.cfg_wr), .cfg_rd(slc_if_i.cfg_rd), .cfg_addr(slc_if_i.cfg_addr),
    .cfg_wdata(slc_if_i.cfg_wdata), .cfg_rdata(slc_if_i.cfg_rdata),
    .cfg_rvalid(slc_if_i.cfg_rvalid), .lane_word(slc_if_i.lane_word),
    .lane_valid(slc_if_i.lane_valid), .lane_ready(slc_if_i.lane_ready));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [135:0] got, input logic [135:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  function automatic slc_word_t map_exp(input logic [7:0] m);
    slc_word_t w;
    int        n;
    w = '0;
    n = (m[3:0] == 4'h1) ? 1 : (m[3:0] == 4'h2) ? 2 : (m[3:0] == 4'h3) ? 4 : 0;
    if (m[3:0] == 4'h7 || m[3:0] == 4'h8) begin
      w.used = 8'h03;
      w.smp[0] = adc_a;
      w.smp[1] = adc_b;
    end
    for (int k = 0; k < n; k++) begin
      if (m[5]) begin
        w.used[k] = 1'b1;
        w.smp[k] = ddc_i[k];
      end else begin
        w.used[2*k+:2] = 2'h3;
        w.smp[2*k] = ddc_i[k];
        w.smp[2*k+1] = ddc_q[k];
      end
    end
    return w;
  endfunction : map_exp
  task automatic set_smp(input logic [15:0] b);
    for (int k = 0; k < `SLC_NDDC; k++) begin
      ddc_i[k] = b ^ 16'(2 * k);
      ddc_q[k] = b ^ 16'(2 * k + 1) ^ 16'h0F00;
    end
    adc_a = b ^ 16'h00F0;
    adc_b = ~b;
  endtask : set_smp
  task automatic rcv(input slc_word_t exp);
    int t;
    t = 0;
    do begin
      @(posedge ref_clk);
      #1;
      t++;
    end while (rx_valid !== 1'b1 && t < 20);
    chk(136'(rx_valid), 136'(1'b1));
    chk(rx_word, exp);
  endtask : rcv
  task automatic send_one(input logic [15:0] b, input logic [7:0] m);
    set_smp(b);
    smp_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    smp_valid = 1'b0;
    rcv(map_exp(m));
  endtask : send_one
  task automatic kick(input logic [7:0] m, input logic [7:0] q, input logic [7:0] d);
    set_mode = m;
    set_qcfg = q;
    set_dcm = d;
    start = 1'b1;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
  endtask : kick
  task automatic cfg_ok(input int i);
    int t;
    kick(tm[i], tq[i], td[i]);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(136'(drv_pd), 136'(1'b1));
    t = 0;
    while (done !== 1'b1 && t < 40) begin
      @(posedge ref_clk);
      #1;
      t++;
    end
    chk(136'(done), 136'(1'b1));
    chk(136'(rate_err), 136'(1'b0));
    chk(136'(low_rate), 136'(tl[i]));
    chk(136'(pll_low_rate), 136'(tl[i]));
    chk(136'(vc_count), 136'(tv[i]));
    chk(136'(lane_mult), 136'(tx[i]));
    chk(136'(m_mismatch), 136'(i == 8));
    chk(136'(cfg_err), 136'(i == 8));
    chk(136'(drv_pd), 136'(1'b0));
    chk(136'(deemph_en), 136'(1'b0));
  endtask : cfg_ok
  task automatic cfg_bad(input logic [7:0] m, input logic [7:0] q, input logic [7:0] d);
    kick(m, q, d);
    chk(136'(rate_err), 136'(1'b1));
    chk(136'(busy), 136'(1'b0));
    chk(136'(vc_count), 136'(4'h8));
    @(posedge ref_clk);
    #1;
  endtask : cfg_bad
  task automatic fifo_fill();
    slc_word_t q[$];
    rx_ready = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    smp_valid = 1'b1;
    for (int k = 0; k < 4; k++) begin
      set_smp(16'h4C00 + 16'(k * 16'h1111));
      q.push_back(map_exp(8'h03));
      @(posedge ref_clk);
      #1;
    end
    chk(136'(smp_ready), 136'(1'b0));
    set_smp(16'hDEAD);
    @(posedge ref_clk);
    #1;
    smp_valid = 1'b0;
    rx_ready = 1'b1;
    foreach (q[k]) rcv(q[k]);
    repeat (8) begin
      @(posedge ref_clk);
      #1;
      chk(136'(rx_valid), 136'(1'b0));
    end
  endtask : fifo_fill
  task automatic reset_chk();
    chk(136'(vc_count), 136'(4'h2));
    chk(136'(lane_mult), 136'(8'h14));
    chk(136'(drv_pd), 136'(1'b0));
    chk(136'(deemph_en), 136'(1'b0));
    chk(136'(pll_low_rate), 136'(1'b0));
    chk(136'(smp_ready), 136'(1'b1));
  endtask : reset_chk
  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, smp_valid, start} = 3'h0;
    rx_ready = 1'b1;
    {set_mode, set_qcfg, set_dcm} = 24'h0;
    set_smp(16'h0000);
    repeat (10) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    @(posedge ref_clk);
    #1;
    reset_chk();
    send_one(16'h8A30, 8'h01);
    for (int i = 0; i < 9; i++) begin
      cfg_ok(i);
      send_one(16'h8A30 ^ 16'(i * 16'h1357), tm[i]);
    end
    cfg_bad(8'h01, 8'h0A, 8'h01);
    cfg_bad(8'h21, 8'h80, 8'h02);
    cfg_bad(8'h01, 8'h49, 8'h00);
    fifo_fill();
    wrap_up();
  end
endmodule : testbench
